// file: shared/hdt_defines.vh
`ifndef HDT_DEFINES_VH
`define HDT_DEFINES_VH

// ----------------------------------------
// Selector encoding
// ----------------------------------------
`define HDT_SEL_W 8
`define HDT_SEL_INVERT 8'h64
`define HDT_SEL_MAX 8'h20

// ----------------------------------------
// Input function codes
// ----------------------------------------
`define HDT_IN_ACC0 8'h01
`define HDT_IN_ACC1 8'h02
`define HDT_IN_SPD0 8'h03
`define HDT_IN_SPD1 8'h04
`define HDT_IN_SPD2 8'h05
`define HDT_IN_FWD 8'h07
`define HDT_IN_REV 8'h08
`define HDT_IN_3WIRE 8'h09
`define HDT_IN_FRST 8'h0d
`define HDT_IN_EXTRST 8'h0e
`define HDT_IN_ESTOP 8'h1d
`define HDT_IN_PULL_UP 8'h1e
`define HDT_IN_PULL_DN 8'h1f
`define HDT_IN_BRAKE_FB 8'h20

// ----------------------------------------
// Output function codes
// ----------------------------------------
`define HDT_OUT_SELFTEST 8'h01
`define HDT_OUT_FAULT 8'h02
`define HDT_OUT_RUN 8'h03
`define HDT_OUT_FREQ 8'h04
`define HDT_OUT_ZERO 8'h06
`define HDT_OUT_BUS 8'h07
`define HDT_OUT_BRAKE 8'h10
`define HDT_OUT_ANTIADH 8'h1d
`define HDT_OUT_LIFTBRK 8'h1e
`define HDT_OUT_BRKSTART 8'h1f

// ----------------------------------------
// Timing
// ----------------------------------------
`define HDT_CLK_HZ 40000000
`define HDT_STARTUP_S 5
`define HDT_STARTUP_CYC (`HDT_STARTUP_S * `HDT_CLK_HZ)
`define HDT_DEBOUNCE_CYC 16'h9c40
`define HDT_FLASH_CYC 24'h989680

`endif

// file: rtl/hdt_debounce.v
`timescale 1ns/1ps
module hdt_debounce #(
    parameter WIDTH = 8,
    parameter CNT_W = 16,
    parameter [CNT_W-1:0] STABLE = 16'h9c40
) (
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Raw pins and filtered levels
    input wire [WIDTH-1:0] raw,
    output reg [WIDTH-1:0] clean
);
    reg [WIDTH-1:0] sync_a;
    reg [WIDTH-1:0] sync_b;
    reg [CNT_W-1:0] cnt [0:WIDTH-1];
    integer i;

    // Two-stage synchroniser; only sync_b is read downstream
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sync_a <= {WIDTH{1'b0}};
            sync_b <= {WIDTH{1'b0}};
        end else begin
            sync_a <= raw;
            sync_b <= sync_a;
        end
    end

    // A level must hold STABLE cycles before it is accepted
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            clean <= {WIDTH{1'b0}};
            for (i = 0; i < WIDTH; i = i + 1) begin
                cnt[i] <= {CNT_W{1'b0}};
            end
        end else begin
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (sync_b[i] == clean[i]) begin
                    cnt[i] <= {CNT_W{1'b0}};
                end else if (cnt[i] >= STABLE - 1'b1) begin
                    cnt[i] <= {CNT_W{1'b0}};
                    clean[i] <= sync_b[i];
                end else begin
                    cnt[i] <= cnt[i] + 1'b1;
                end
            end
        end
    end
endmodule // hdt_debounce

// file: rtl/hdt_keypad.v
`timescale 1ns/1ps
module hdt_keypad (
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Debounced key levels
    input wire [8:0] keys_in,
    // One-cycle press pulses
    output reg [8:0] key_press
);
    reg [8:0] prev;

    // Rising edge of each debounced key gives one pulse
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prev <= 9'h000;
            key_press <= 9'h000;
        end else begin
            prev <= keys_in;
            key_press <= keys_in & ~prev;
        end
    end
endmodule // hdt_keypad

// file: rtl/hdt_terminal.v
// Functional notes
// - Eight inputs each have function selector
// - Selector zero input asserts nothing
// - Codes 1,2 drive accel profile bits
// - Codes 3-5 drive speed index bits
// - Code 7 up, code 8 down
// - 9 three-wire, 13 fault reset, 14 external
// - 29 estop, 30/31 pull mode, 32 brake
// - Hundred-prefix input acts normally closed
// - Six outputs each have function selector
// - Selector zero output never active
// - Outputs 1 selftest, 2 fault, 3 running
// - Outputs 4 freq, 6 zero-speed, 7 bus
// - Outputs 16,29,30,31 brake related statuses
// - Hundred-prefix output is inverted
// - Active picks relay or pulls low
// - Two relays and four open-collector channels
// - Four lamps show run, direction, source, fault
// - Run-dim key dims or runs locally
// - Stop-brighten key brightens or stops locally
// - Source toggle switches local and remote
// - Enter descends, escape ascends menu levels
// - Monitoring appears five seconds after power
`timescale 1ns/1ps
`include "hdt_defines.vh"
module hdt_terminal #(
    parameter [31:0] STARTUP_CYC = `HDT_STARTUP_CYC,
    parameter [15:0] DEBOUNCE_CYC = `HDT_DEBOUNCE_CYC,
    parameter [23:0] FLASH_CYC = `HDT_FLASH_CYC
) (
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Input terminals and their selectors
    input wire [7:0] term_in,
    input wire [63:0] input_function_selectors,
    // Output selectors
    input wire [47:0] output_function_selectors,
    // Drive status
    input wire stat_selftest_ok,
    input wire stat_fault,
    input wire stat_warning,
    input wire stat_running,
    input wire stat_dir_up,
    input wire stat_freq_reached,
    input wire stat_zero_speed,
    input wire stat_bus_ok,
    input wire stat_brake,
    input wire stat_antiadh,
    input wire stat_lift_brake,
    input wire stat_brake_start,
    // Panel keys: right,left,inc,dec,enter,esc,run_dim,stop_brighten,source_toggle
    input wire [8:0] panel_keys,
    // Decoded commands
    output reg [1:0] accel_select,
    output reg [2:0] speed_select,
    output reg cmd_fwd,
    output reg cmd_rev,
    output reg three_wire,
    output reg fault_reset,
    output reg ext_fault_reset,
    output reg emergency_stop,
    output reg pull_rise,
    output reg pull_decline,
    output reg brake_feedback,
    // Panel commands and state
    output reg panel_run,
    output reg command_source_select,
    output reg dim_pulse,
    output reg brighten_pulse,
    output reg [3:0] panel_state,
    // Output terminals: relays high = energised, OC oe high = pulling low
    output reg [1:0] relay_drive,
    output reg [3:0] oc_out,
    output reg [3:0] oc_oe,
    // Lamps
    output reg run_lamp,
    output reg direction_lamp,
    output reg local_remote_lamp,
    output reg fault_lamp
);
    // ----------------------------------------
    // States and helpers
    // ----------------------------------------
    localparam ST_BOOT = 4'b0001;
    localparam ST_MON = 4'b0010;
    localparam ST_FSEL = 4'b0100;
    localparam ST_FUNC = 4'b1000;
    localparam K_ENTER = 4;
    localparam K_ESC = 5;
    localparam K_RUN = 6;
    localparam K_STOP = 7;
    localparam K_SRC = 8;

    wire [7:0] pin_clean;
    wire [8:0] key_clean;
    wire [8:0] key_press;
    reg [31:0] boot_cnt;
    reg [23:0] flash_cnt;
    reg flash;
    reg [3:0] next_state;
    reg [31:0] in_act;
    reg [5:0] next_out;
    reg [7:0] code;
    reg [7:0] ocode;
    integer t, u;
    wire [11:0] stat_vec = {2'b00, stat_brake_start, stat_lift_brake, stat_antiadh, stat_brake,
        stat_bus_ok, stat_zero_speed, stat_freq_reached, stat_running, stat_fault,
        stat_selftest_ok};

    // Strip the hundreds prefix; any value outside both ranges is no function
    function [7:0] base_code;
        input [7:0] s;
        begin
            if (s >= `HDT_SEL_INVERT && s <= `HDT_SEL_INVERT + `HDT_SEL_MAX) begin
                base_code = s - `HDT_SEL_INVERT;
            end else if (s <= `HDT_SEL_MAX) begin
                base_code = s;
            end else begin
                base_code = 8'h00;
            end
        end
    endfunction
    function is_inverted;
        input [7:0] s;
        begin
            is_inverted = (s >= `HDT_SEL_INVERT) && (s <= `HDT_SEL_INVERT + `HDT_SEL_MAX);
        end
    endfunction

    // ----------------------------------------
    // Input conditioning
    // ----------------------------------------
    hdt_debounce #(.WIDTH(8), .CNT_W(16), .STABLE(DEBOUNCE_CYC)) u_pin_db (
        .mclk(mclk),
        .reset_n(reset_n),
        .raw(term_in),
        .clean(pin_clean)
    );

    hdt_debounce #(.WIDTH(9), .CNT_W(16), .STABLE(DEBOUNCE_CYC)) u_key_db (
        .mclk(mclk),
        .reset_n(reset_n),
        .raw(panel_keys),
        .clean(key_clean)
    );

    hdt_keypad u_keys (
        .mclk(mclk),
        .reset_n(reset_n),
        .keys_in(key_clean),
        .key_press(key_press)
    );

    // ----------------------------------------
    // Input function decode
    // ----------------------------------------
    // Functions OR together when several terminals share one code
    always @* begin
        in_act = 32'h0000_0000;
        code = 8'h00;
        for (t = 0; t < 8; t = t + 1) begin
            code = base_code(input_function_selectors[t*8 +: 8]);
            if (code != 8'h00 &&
                (pin_clean[t] ^ is_inverted(input_function_selectors[t*8 +: 8]))) begin
                in_act[code[4:0] - 5'd1] = 1'b1;
            end
        end
    end

    // Slot n-1 holds code n; code 32 wraps to slot 31
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            {accel_select, speed_select, cmd_fwd, cmd_rev, three_wire, fault_reset,
                ext_fault_reset, emergency_stop, pull_rise, pull_decline,
                brake_feedback} <= 14'h0000;
        end else begin
            accel_select <= in_act[1:0];
            speed_select <= in_act[4:2];
            cmd_fwd <= in_act[6];
            cmd_rev <= in_act[7];
            three_wire <= in_act[8];
            fault_reset <= in_act[12];
            ext_fault_reset <= in_act[13];
            emergency_stop <= in_act[28];
            pull_rise <= in_act[29];
            pull_decline <= in_act[30];
            brake_feedback <= in_act[31];
        end
    end

    // ----------------------------------------
    // Output function select
    // ----------------------------------------
    function status_of;
        input [7:0] c;
        input [11:0] st;
        begin
            case (c)
                `HDT_OUT_SELFTEST: status_of = st[0];
                `HDT_OUT_FAULT: status_of = st[1];
                `HDT_OUT_RUN: status_of = st[2];
                `HDT_OUT_FREQ: status_of = st[3];
                `HDT_OUT_ZERO: status_of = st[4];
                `HDT_OUT_BUS: status_of = st[5];
                `HDT_OUT_BRAKE: status_of = st[6];
                `HDT_OUT_ANTIADH: status_of = st[7];
                `HDT_OUT_LIFTBRK: status_of = st[8];
                `HDT_OUT_BRKSTART: status_of = st[9];
                default: status_of = 1'b0;
            endcase
        end
    endfunction

    // Unused selectors stay released even with the prefix set;
    // an all-ones status vector reads back 1 only for assigned codes
    always @* begin
        next_out = 6'b000000;
        ocode = 8'h00;
        for (u = 0; u < 6; u = u + 1) begin
            ocode = base_code(output_function_selectors[u*8 +: 8]);
            if (status_of(ocode, 12'hfff)) begin
                next_out[u] = status_of(ocode, stat_vec) ^
                    is_inverted(output_function_selectors[u*8 +: 8]);
            end
        end
    end

    // Channels 0-1 are relays, 2-5 are open collectors
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            relay_drive <= 2'b00;
            oc_out <= 4'h0;
            oc_oe <= 4'h0;
        end else begin
            relay_drive <= next_out[1:0];
            oc_out <= 4'h0;
            oc_oe <= next_out[5:2];
        end
    end

    // ----------------------------------------
    // Panel state machine
    // ----------------------------------------
    // Boot counter runs once after reset
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            boot_cnt <= 32'h0000_0000;
        end else if (panel_state == ST_BOOT) begin
            boot_cnt <= boot_cnt + 32'h0000_0001;
        end
    end

    always @* begin
        next_state = panel_state;
        case (panel_state)
            ST_BOOT: begin
                if (boot_cnt >= STARTUP_CYC - 32'h0000_0001) begin
                    next_state = ST_MON;
                end
            end
            ST_MON: begin
                if (key_press[K_ENTER]) begin
                    next_state = ST_FSEL;
                end
            end
            ST_FSEL: begin
                if (key_press[K_ENTER]) begin
                    next_state = ST_FUNC;
                end else if (key_press[K_ESC]) begin
                    next_state = ST_MON;
                end
            end
            ST_FUNC: begin
                if (key_press[K_ESC]) begin
                    next_state = ST_FSEL;
                end
            end
            default: next_state = ST_BOOT;
        endcase
    end

    // Keys act only after start-up so stray presses do not start the hoist
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            panel_state <= ST_BOOT;
            panel_run <= 1'b0;
            command_source_select <= 1'b0;
            dim_pulse <= 1'b0;
            brighten_pulse <= 1'b0;
        end else begin
            panel_state <= next_state;
            dim_pulse <= key_press[K_RUN] && panel_state == ST_MON && !command_source_select;
            brighten_pulse <= key_press[K_STOP] && panel_state == ST_MON &&
                !command_source_select;
            if (panel_state != ST_BOOT && key_press[K_SRC]) begin
                command_source_select <= ~command_source_select;
                panel_run <= 1'b0;
            end else if (command_source_select && key_press[K_STOP]) begin
                panel_run <= 1'b0;
            end else if (command_source_select && key_press[K_RUN] && !stat_fault) begin
                panel_run <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Lamps
    // ----------------------------------------
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            flash_cnt <= 24'h000000;
            flash <= 1'b0;
        end else if (flash_cnt >= FLASH_CYC - 24'h000001) begin
            flash_cnt <= 24'h000000;
            flash <= ~flash;
        end else begin
            flash_cnt <= flash_cnt + 24'h000001;
        end
    end

    // Fault or warning overrides run; in local mode the panel run latch also lights the run lamp
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            {run_lamp, direction_lamp, local_remote_lamp, fault_lamp} <= 4'h0;
        end else begin
            run_lamp <= !(stat_fault || stat_warning) &&
                (stat_running || (command_source_select && panel_run));
            direction_lamp <= stat_running && stat_dir_up;
            local_remote_lamp <= command_source_select;
            fault_lamp <= (stat_fault || stat_warning) && flash;
        end
    end
endmodule // hdt_terminal

// file: tb/hdt_terminal_sva.sv
`timescale 1ns/1ps
module hdt_terminal_sva #(
    parameter [31:0] STARTUP_CYC = 32'd200000000
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Watched inputs
    input wire logic [7:0] term_in,
    input wire logic [63:0] input_function_selectors,
    input wire logic [47:0] output_function_selectors,
    input wire logic stat_fault,
    input wire logic stat_running,
    input wire logic stat_dir_up,
    // Watched outputs
    input wire logic cmd_fwd,
    input wire logic dim_pulse,
    input wire logic [3:0] panel_state,
    input wire logic [1:0] relay_drive,
    input wire logic [3:0] oc_out,
    input wire logic [3:0] oc_oe,
    input wire logic run_lamp,
    input wire logic direction_lamp
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    logic [31:0] up_cnt;
    // Cycles since reset release; saturates so it never wraps into boot
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            up_cnt <= 32'h0;
        end else if (up_cnt != 32'hffffffff) begin
            up_cnt <= up_cnt + 32'h1;
        end
    end
    // Contact on terminal 0 closes and stays closed as a forward switch
    sequence s_fwd_held;
        $rose(term_in[0]) ##0 (term_in[0] && input_function_selectors[7:0] == 8'h07)[*8];
    endsequence
    property p_fwd_decode;
        s_fwd_held |-> ##[0:4] cmd_fwd;
    endproperty
    property p_out_unused;
        output_function_selectors[7:0] == 8'h00 |=> !relay_drive[0];
    endproperty
    property p_out_run;
        output_function_selectors[7:0] == 8'h03 |=> relay_drive[0] == $past(stat_running);
    endproperty
    property p_out_inverted;
        output_function_selectors[23:16] == 8'h67 |=> oc_oe[0] == !$past(stat_running);
    endproperty
    property p_oc_level;
        oc_out == 4'h0;
    endproperty
    property p_fault_dark;
        stat_fault |=> !run_lamp;
    endproperty
    property p_dir_lamp;
        1'b1 |=> direction_lamp == ($past(stat_running) && $past(stat_dir_up));
    endproperty
    property p_dim_single;
        dim_pulse |=> !dim_pulse;
    endproperty
    property p_state_onehot;
        $onehot(panel_state);
    endproperty
    property p_boot_hold;
        up_cnt < STARTUP_CYC - 32'd3 |-> panel_state == 4'h1;
    endproperty
    property p_boot_left;
        up_cnt > STARTUP_CYC + 32'd3 |-> panel_state != 4'h1;
    endproperty
    a_fwd_decode: assert property (p_fwd_decode)
        else $error("Forward command missing after held contact");
    a_out_unused: assert property (p_out_unused)
        else $error("Unused relay energised");
    a_out_run: assert property (p_out_run)
        else $error("Running relay wrong");
    a_out_inverted: assert property (p_out_inverted)
        else $error("Inverted output wrong");
    a_oc_level: assert property (p_oc_level)
        else $error("Open-collector driven high");
    a_fault_dark: assert property (p_fault_dark)
        else $error("Run lamp lit during fault");
    a_dir_lamp: assert property (p_dir_lamp)
        else $error("Direction lamp wrong");
    a_dim_single: assert property (p_dim_single)
        else $error("Dim pulse too long");
    a_state_onehot: assert property (p_state_onehot)
        else $error("Panel state not one-hot");
    a_boot_hold: assert property (p_boot_hold)
        else $error("Boot left early");
    a_boot_left: assert property (p_boot_left)
        else $error("Boot not left");
endmodule // hdt_terminal_sva

bind hdt_terminal hdt_terminal_sva #(.STARTUP_CYC(STARTUP_CYC)) u_sva (
    .mclk(mclk), .reset_n(reset_n), .term_in(term_in),
    .input_function_selectors(input_function_selectors),
    .output_function_selectors(output_function_selectors),
    .stat_fault(stat_fault), .stat_running(stat_running), .stat_dir_up(stat_dir_up),
    .cmd_fwd(cmd_fwd), .dim_pulse(dim_pulse), .panel_state(panel_state),
    .relay_drive(relay_drive), .oc_out(oc_out), .oc_oe(oc_oe),
    .run_lamp(run_lamp), .direction_lamp(direction_lamp)
);

// file: tb/hdt_field.sv
`timescale 1ns/1ps
module hdt_field (
    // Wanted contact and key levels
    input wire logic [7:0] want_term,
    input wire logic [8:0] want_keys,
    // Device pins
    output logic [7:0] term_in,
    output logic [8:0] panel_keys,
    input wire logic [3:0] oc_out,
    input wire logic [3:0] oc_oe,
    // Open-collector lines with external pull-up
    output logic [3:0] oc_pin
);
    // Clean contacts; bouncing is played by the bench itself
    assign term_in = want_term;
    assign panel_keys = want_keys;
    // Pull-up wins unless the output stage sinks the line
    assign oc_pin = (oc_oe & oc_out) | ~oc_oe;
endmodule // hdt_field

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] want_term = 8'h00;
    logic [8:0] want_keys = 9'h000;
    logic [63:0] isel = 64'h0;
    logic [47:0] osel = 48'h0;
    logic [11:0] stat = 12'h000;
    logic [7:0] c;
    logic [15:0] ec, eo;
    logic [3:0] e;
    logic prev;
    int fail_count = 0;
    int cmp_count = 0;
    int n, nd, nb;
    wire [7:0] term_in;
    wire [8:0] panel_keys;
    wire [1:0] accel, relay;
    wire [2:0] speed;
    wire [8:0] cmd1;
    wire [3:0] pstate, oc_out, oc_oe, oc_pin;
    wire prun, src, dim, bri, rl, dl, ll, fl;
    wire [13:0] cmds = {accel, speed, cmd1};
    // Rows: selector, status vector, expected active
    localparam logic [23:0] OROWS [17] = '{24'h00fff0, 24'h018001, 24'h024001,
        24'h031001, 24'h03eff0, 24'h040401, 24'h060201, 24'h070101, 24'h100081,
        24'h1d0041, 24'h1e0021, 24'h1f0011, 24'h1fffe0, 24'h670001, 24'h671000,
        24'h64fff0, 24'h05fff0};
    // Rows: code, commands with contact closed, commands with contact open
    localparam logic [39:0] IROWS [18] = '{40'h07_0100_0000, 40'h01_1000_0000,
        40'h02_2000_0000, 40'h03_0200_0000, 40'h04_0400_0000, 40'h05_0800_0000,
        40'h08_0080_0000, 40'h09_0040_0000, 40'h0d_0020_0000, 40'h0e_0010_0000,
        40'h1d_0008_0000, 40'h1e_0004_0000, 40'h1f_0002_0000, 40'h20_0001_0000,
        40'h00_0000_0000, 40'h06_0000_0000, 40'h21_0000_0000, 40'h6b_0000_0100};

    always #12.5 mclk = ~mclk;

    hdt_field field (.want_term(want_term), .want_keys(want_keys), .term_in(term_in),
        .panel_keys(panel_keys), .oc_out(oc_out), .oc_oe(oc_oe), .oc_pin(oc_pin));

    // Short counts keep boot, debounce and flashing within a few cycles
    hdt_terminal #(.STARTUP_CYC(32'd100), .DEBOUNCE_CYC(16'd4), .FLASH_CYC(24'd8)) dut (
        .mclk(mclk), .reset_n(reset_n), .term_in(term_in),
        .input_function_selectors(isel), .output_function_selectors(osel),
        .stat_selftest_ok(stat[11]), .stat_fault(stat[10]), .stat_warning(stat[9]),
        .stat_running(stat[8]), .stat_dir_up(stat[7]), .stat_freq_reached(stat[6]),
        .stat_zero_speed(stat[5]), .stat_bus_ok(stat[4]), .stat_brake(stat[3]),
        .stat_antiadh(stat[2]), .stat_lift_brake(stat[1]), .stat_brake_start(stat[0]),
        .panel_keys(panel_keys), .accel_select(accel), .speed_select(speed),
        .cmd_fwd(cmd1[8]), .cmd_rev(cmd1[7]), .three_wire(cmd1[6]), .fault_reset(cmd1[5]),
        .ext_fault_reset(cmd1[4]), .emergency_stop(cmd1[3]), .pull_rise(cmd1[2]),
        .pull_decline(cmd1[1]), .brake_feedback(cmd1[0]), .panel_run(prun),
        .command_source_select(src), .dim_pulse(dim), .brighten_pulse(bri),
        .panel_state(pstate), .relay_drive(relay), .oc_out(oc_out), .oc_oe(oc_oe),
        .run_lamp(rl), .direction_lamp(dl), .local_remote_lamp(ll), .fault_lamp(fl));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: %s", $time, what);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #2;
    endtask

    // Holds a key long enough to pass the filter, counting panel pulses
    task automatic press(input int k);
        nd = 0;
        nb = 0;
        want_keys = 9'(1) << k;
        for (int j = 0; j < 20; j++) begin
            cyc(1);
            if (dim === 1'b1) nd++;
            if (bri === 1'b1) nb++;
            // Release early so the filter sees the key drop before the next press
            if (j == 9) want_keys = 9'h000;
        end
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Watchdog sized well above the roughly 840 cycles the tests need
    initial begin
        #(25 * 6000);
        fail_count++;
        conclude;
    end

    initial begin
        cyc(3);
        check(16'({pstate, relay, oc_oe, rl, dl, ll, fl}), 16'h0400, "reset");
        cyc(5);
        reset_n = 1'b1;
        n = 0;
        while (pstate !== 4'h2 && n < 300) begin
            cyc(1);
            n++;
        end
        check(16'(n >= 96 && n <= 104), 16'h1, "boot delay");
        foreach (OROWS[i]) begin
            {c, stat, e} = OROWS[i];
            osel = {6{c}};
            cyc(2);
            check(16'({relay, oc_oe}), {10'h0, {6{e[0]}}}, "outputs");
            check(16'(oc_pin), {12'h0, {4{~e[0]}}}, "oc level");
        end
        stat = 12'h000;
        foreach (IROWS[i]) begin
            {c, ec, eo} = IROWS[i];
            isel = 64'(c) << ((i % 8) * 8);
            want_term = 8'(1) << (i % 8);
            cyc(12);
            check(16'(cmds), ec, "closed");
            want_term = 8'h00;
            cyc(12);
            check(16'(cmds), eo, "open");
        end
        isel = 64'h07;
        want_term = 8'h01;
        cyc(2);
        want_term = 8'h00;
        cyc(12);
        check(16'(cmd1[8]), 16'h0, "glitch");
        n = 0;
        press(6);
        check(16'({nd[3:0], nb[3:0]}), 16'h10, "dim");
        press(7);
        check(16'({nd[3:0], nb[3:0]}), 16'h01, "brighten");
        press(4);
        check(16'(pstate), 16'h4, "enter");
        press(4);
        check(16'(pstate), 16'h8, "enter 2");
        press(5);
        check(16'(pstate), 16'h4, "esc");
        press(5);
        check(16'(pstate), 16'h2, "esc 2");
        press(8);
        check(16'({src, ll}), 16'h3, "local");
        press(6);
        check(16'({prun, rl, nd[3:0]}), 16'h30, "local run");
        stat = 12'h400;
        cyc(2);
        check(16'(rl), 16'h0, "fault dark");
        n = 0;
        repeat (40) begin
            prev = fl;
            cyc(1);
            if (fl !== prev) n++;
        end
        check(16'(n >= 4 && n <= 5), 16'h1, "flash");
        stat = 12'h200;
        cyc(2);
        check(16'(rl), 16'h0, "warning dark");
        stat = 12'h000;
        n = 0;
        press(7);
        check(16'({prun, nb[3:0]}), 16'h0, "local stop");
        press(8);
        check(16'({src, ll}), 16'h0, "remote");
        stat = 12'h180;
        cyc(2);
        check(16'({rl, dl}), 16'h3, "up");
        stat = 12'h100;
        cyc(2);
        check(16'({rl, dl}), 16'h2, "down");
        reset_n = 1'b0;
        cyc(1);
        check(16'(pstate), 16'h1, "second reset");
        reset_n = 1'b1;
        cyc(4);
        check(16'({pstate, src, prun}), 16'h04, "after reset");
        conclude;
    end
endmodule // tb
